// ==== logic/flash_err_pkg.sv ====
package flash_err_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CAPTURED_ADDRESS = 8'h03;
    localparam logic [7:0] IDX_PROGRAM_DATA = 8'h04;
    localparam logic [7:0] IDX_EVENT_ENABLE = 8'h05;
    localparam logic [7:0] IDX_EVENT_SOURCE = 8'h06;
    localparam logic [7:0] IDX_EVENT_PENDING = 8'h07;
    localparam logic [9:0] ADDR_CAPTURED_ADDRESS = 10'h00C;
    localparam logic [9:0] ADDR_PROGRAM_DATA = 10'h010;
    localparam logic [9:0] ADDR_EVENT_ENABLE = 10'h014;
    localparam logic [9:0] ADDR_EVENT_SOURCE = 10'h018;
    localparam logic [9:0] ADDR_EVENT_PENDING = 10'h01C;
    localparam int EVENT_COUNT = 12;
    localparam int BIT_BUSY_WRITE = 11;
    localparam int BIT_CTRL_WRITE = 10;
    localparam int BIT_TIMER_LO = 3;
    localparam int BIT_ERASE_ACCESS = 2;
    localparam int BIT_PROGRAM_ACCESS = 1;
    localparam int BIT_OUT_OF_RANGE = 0;
    localparam int TIMER_COUNT = 7;
    localparam logic [15:0] RST_CAPTURED_ADDRESS = 16'h0000;
    localparam logic [15:0] RST_PROGRAM_DATA = 16'h0000;
    localparam logic [11:0] RST_EVENT_ENABLE = 12'h000;
    localparam logic [11:0] RST_EVENT_SOURCE = 12'h000;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage

// ==== logic/sticky_event_bits.sv ====
`timescale 1ns/1ps
`default_nettype none
module sticky_event_bits #(
    parameter int WIDTH = 12
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] bits_o
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("WIDTH must be positive");
        end
    endgenerate
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    bits_o[g] <= 1'b0;
                end else if (ce_i) begin
                    // Set beats a same-cycle clear so no event is lost
                    bits_o[g] <= set_i[g] | (bits_o[g] & ~clr_i[g]);
                end
            end
        end
    endgenerate
endmodule // sticky_event_bits
`default_nettype wire

// ==== logic/hold_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module hold_reg #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q_o <= RESET_VALUE;
        end else if (ce_i && load_i) begin
            q_o <= d_i;
        end
    end
endmodule // hold_reg
`default_nettype wire

// ==== logic/flash_iface_error_status.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Twelve-bit enable mask, one bit per event; one enables, upper bits reserved.
// - Source bit 11 sets on a register write while the unit is busy.
// - Source bit 10 sets on a control write during program or erase.
// - Bits 9..3 flag erase, recovery, program, setup, hold2, hold, nv setup expiry.
// - Source bit 2 sets on a flash access during erase.
// - Source bit 1 sets on a flash access during program, except an in-range write.
// - Source bit 0 sets on a flash access outside the valid range.
// - Source bits read zero after reset; one means the event occurred.
// - Sixteen-bit program data register holds last programmed value, resets zero.
// - Pending bits equal source AND enable, same bit layout.
module flash_iface_error_status #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16,
    parameter logic [ADDR_W-1:0] FLASH_LIMIT = 16'h7FFF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [9:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Status from the flash sequencer
    input wire logic unit_busy_i,
    input wire logic program_active_i,
    input wire logic erase_active_i,
    input wire logic iface_reg_write_i,
    input wire logic control_write_i,
    input wire logic [6:0] timer_expired_i,
    // Flash array access attempt
    input wire logic flash_access_i,
    input wire logic flash_write_i,
    input wire logic pe_access_i,
    input wire logic [ADDR_W-1:0] flash_addr_i,
    input wire logic [DATA_W-1:0] flash_wdata_i,
    output logic irq_o,
    output logic [11:0] event_pending_bits_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the register words are laid out for these sizes
    generate
        if (ADDR_W != 16) begin : g_bad_addr_w
            $error("ADDR_W must be 16");
        end
        if (DATA_W != 16) begin : g_bad_data_w
            $error("DATA_W must be 16");
        end
        if (flash_err_pkg::EVENT_COUNT != 12) begin : g_bad_event_count
            $error("EVENT_COUNT must be 12");
        end
        if (flash_err_pkg::TIMER_COUNT != 7) begin : g_bad_timer_count
            $error("TIMER_COUNT must be 7");
        end
        if (flash_err_pkg::BIT_TIMER_LO + flash_err_pkg::TIMER_COUNT
            != flash_err_pkg::BIT_CTRL_WRITE) begin : g_bad_timer_field
            $error("Timer field must sit just below the control write bit");
        end
        if (FLASH_LIMIT == '0) begin : g_bad_limit
            $error("FLASH_LIMIT must leave more than one valid address");
        end
    endgenerate

    localparam int N = flash_err_pkg::EVENT_COUNT;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
        hit = (a == target);
    endfunction

    // True when an access lands past the last valid flash word
    function automatic logic beyond_limit(input logic [ADDR_W-1:0] a);
        beyond_limit = (a > FLASH_LIMIT);
    endfunction

    // Widen a field to the bus word; reserved bits read zero
    function automatic logic [31:0] word16(input logic [15:0] v);
        word16 = {16'h0000, v};
    endfunction

    function automatic logic [31:0] word12(input logic [11:0] v);
        word12 = {20'h00000, v};
    endfunction

    logic [N-1:0] event_enable_bits_r;
    logic [N-1:0] event_source_bits;
    logic [N-1:0] event_set;
    logic [N-1:0] event_clr;
    logic [N-1:0] event_pending_nxt;
    logic [ADDR_W-1:0] captured_address_reg;
    logic [DATA_W-1:0] program_data_reg;
    logic [31:0] rdata_nxt;
    logic irq_nxt;

    ////////////////////////////////////////////////////////////////////////////
    wire sel_addr = hit(reg_addr_i, flash_err_pkg::ADDR_CAPTURED_ADDRESS);
    wire sel_data = hit(reg_addr_i, flash_err_pkg::ADDR_PROGRAM_DATA);
    wire sel_en = hit(reg_addr_i, flash_err_pkg::ADDR_EVENT_ENABLE);
    wire sel_src = hit(reg_addr_i, flash_err_pkg::ADDR_EVENT_SOURCE);
    wire sel_pend = hit(reg_addr_i, flash_err_pkg::ADDR_EVENT_PENDING);
    wire en_write = reg_wr_i && sel_en;
    wire src_write = reg_wr_i && sel_src;

    ////////////////////////////////////////////////////////////////////////////
    // Access classification
    wire out_of_range = flash_access_i && beyond_limit(flash_addr_i);
    wire in_range_access = flash_access_i && !out_of_range;
    wire capture_data = in_range_access && flash_write_i && program_active_i;

    // Named event conditions, one per source bit
    wire busy_write_hit = iface_reg_write_i && unit_busy_i;
    wire pe_in_progress = program_active_i || erase_active_i;
    wire ctrl_write_hit = control_write_i && pe_in_progress;
    wire erase_access_hit = flash_access_i && erase_active_i;
    // A legal in-range program write is the operation itself, not a fault
    wire program_access_hit = flash_access_i && program_active_i && !capture_data;
    wire range_hit = out_of_range;
    wire [flash_err_pkg::TIMER_COUNT-1:0] timer_hit;

    // One lane per timing interval; lane k lands on source bit k+3
    genvar t;
    generate
        for (t = 0; t < flash_err_pkg::TIMER_COUNT; t++) begin : g_timer
            assign timer_hit[t] = timer_expired_i[t];
        end
    endgenerate
    wire erase_time_hit = timer_hit[6];
    wire recovery_time_hit = timer_hit[5];
    wire program_time_hit = timer_hit[4];
    wire program_setup_hit = timer_hit[3];
    wire second_nv_hold_time_hit = timer_hit[2];
    wire nv_hold_time_hit = timer_hit[1];
    wire nv_setup_time_hit = timer_hit[0];

    ////////////////////////////////////////////////////////////////////////////
    // Event sources
    always_comb begin
        event_set = '0;
        event_set[flash_err_pkg::BIT_BUSY_WRITE] = busy_write_hit;
        event_set[flash_err_pkg::BIT_CTRL_WRITE] = ctrl_write_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 6] = erase_time_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 5] = recovery_time_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 4] = program_time_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 3] = program_setup_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 2] = second_nv_hold_time_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO + 1] = nv_hold_time_hit;
        event_set[flash_err_pkg::BIT_TIMER_LO] = nv_setup_time_hit;
        event_set[flash_err_pkg::BIT_ERASE_ACCESS] = erase_access_hit;
        event_set[flash_err_pkg::BIT_PROGRAM_ACCESS] = program_access_hit;
        event_set[flash_err_pkg::BIT_OUT_OF_RANGE] = range_hit;
    end

    // Write one to clear, lane by lane
    genvar c;
    generate
        for (c = 0; c < N; c++) begin : g_clear
            assign event_clr[c] = src_write && reg_wdata_i[c];
        end
    endgenerate

    // Mask does not feed the set path
    sticky_event_bits #(
        .WIDTH(N)
    ) u_source (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(event_set),
        .clr_i(event_clr),
        .bits_o(event_source_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    hold_reg #(
        .WIDTH(ADDR_W),
        .RESET_VALUE(flash_err_pkg::RST_CAPTURED_ADDRESS)
    ) u_captured_address (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(pe_access_i),
        .d_i(flash_addr_i),
        .q_o(captured_address_reg)
    );

    hold_reg #(
        .WIDTH(DATA_W),
        .RESET_VALUE(flash_err_pkg::RST_PROGRAM_DATA)
    ) u_program_data (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(capture_data),
        .d_i(flash_wdata_i),
        .q_o(program_data_reg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Enable bits, one flop per lane; written bits above the lanes are dropped
    genvar e;
    generate
        for (e = 0; e < N; e++) begin : g_enable
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    event_enable_bits_r[e] <= flash_err_pkg::RST_EVENT_ENABLE[e];
                end else if (ce_i && en_write) begin
                    event_enable_bits_r[e] <= reg_wdata_i[e];
                end
            end
        end
    endgenerate

    // Pending from next source and enable state so the outputs match the registers
    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_pending
            wire src_lane = event_set[p] | (event_source_bits[p] & ~event_clr[p]);
            wire en_lane = en_write ? reg_wdata_i[p] : event_enable_bits_r[p];
            // Same lane assignment as the source bits
            assign event_pending_nxt[p] = src_lane & en_lane;
        end
    endgenerate
    assign irq_nxt = |event_pending_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Each register as a bus word
    wire [31:0] word_addr = word16(captured_address_reg);
    wire [31:0] word_data = word16(program_data_reg);
    wire [31:0] word_en = word12(event_enable_bits_r);
    wire [31:0] word_src = word12(event_source_bits);
    wire [31:0] word_pend = word12(event_source_bits & event_enable_bits_r);

    always_comb begin
        rdata_nxt = flash_err_pkg::RD_UNMAPPED;
        if (sel_addr) begin
            rdata_nxt = word_addr;
        end else if (sel_data) begin
            rdata_nxt = word_data;
        end else if (sel_en) begin
            rdata_nxt = word_en;
        end else if (sel_src) begin
            rdata_nxt = word_src;
        end else if (sel_pend) begin
            rdata_nxt = word_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            // Zero outside the answer cycle so stale data never lingers
            reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= irq_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            event_pending_bits_o <= 12'h000;
        end else if (ce_i) begin
            event_pending_bits_o <= event_pending_nxt;
        end
    end
endmodule // flash_iface_error_status
`default_nettype wire

// ==== verif/flash_iface_error_status_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_err_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic unit_busy_i,
    input wire logic program_active_i,
    input wire logic erase_active_i,
    input wire logic iface_reg_write_i,
    input wire logic control_write_i,
    input wire logic [6:0] timer_expired_i,
    input wire logic irq_o,
    input wire logic [11:0] event_pending_bits_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic mapped = reg_addr_i[9:5] == 5'h00 && reg_addr_i[1:0] == 2'h0
        && reg_addr_i[4:2] >= 3'h3;
    wire logic [11:0] pnd = event_pending_bits_o;
    sequence s_read_nomap;
        reg_rd_i && ce_i && !mapped;
    endsequence
    a_irq_is_pending: assert property (irq_o == |pnd)
        else $error("irq differs from pending bits");
    a_idle_rdata: assert property (!reg_rd_i && ce_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (s_read_nomap |=> reg_rdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_pending_sticky: assert property (!reg_wr_i |=> (pnd & $past(pnd)) == $past(pnd))
        else $error("pending bit dropped without write");
    a_reset_clear: assert property (disable iff (1'b0) rst_i && ce_i |=>
        pnd == 12'h000 && !irq_o && reg_rdata_o == 32'h00000000)
        else $error("outputs not cleared by reset");
    a_ctrl_cause: assert property ($rose(pnd[10]) |-> $past(reg_wr_i)
        || $past(control_write_i && (program_active_i || erase_active_i)))
        else $error("bit 10 set without cause");
    a_busy_cause: assert property ($rose(pnd[11]) |-> $past(reg_wr_i)
        || $past(iface_reg_write_i && unit_busy_i))
        else $error("bit 11 set without cause");
    a_timer_cause: assert property ((pnd[9:3] & ~$past(pnd[9:3])
        & ~$past(timer_expired_i)) != 7'h00 |-> $past(reg_wr_i))
        else $error("timer bit set without its expiry");
endmodule // flash_err_checker
bind flash_iface_error_status flash_err_checker i_chk (.*);
`default_nettype wire

// ==== verif/flash_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_seq_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] go_i,
    input wire logic [6:0] tsel_i,
    output logic busy_o,
    output logic prog_o,
    output logic erase_o,
    output logic [6:0] timer_o
);
    logic [4:0] cnt_r;
    logic [1:0] mode_r;
    assign busy_o = cnt_r != 5'h00;
    assign prog_o = busy_o & mode_r[0];
    assign erase_o = busy_o & mode_r[1];
    // Chosen interval expires as the operation ends
    always_ff @(posedge clk_sys_i) begin
        timer_o <= (cnt_r == 5'h01) ? tsel_i : 7'h00;
        cnt_r <= rst_i ? 5'h00 : (go_i != 2'h0) ? 5'h10 : busy_o ? cnt_r - 5'h01 : cnt_r;
        mode_r <= (go_i != 2'h0) ? go_i : mode_r;
    end
endmodule // flash_seq_model
`default_nettype wire

// ==== verif/tb_flash_iface_error_status.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_flash_iface_error_status;
    localparam logic [9:0] CAP = flash_err_pkg::ADDR_CAPTURED_ADDRESS;
    localparam logic [9:0] DAT = flash_err_pkg::ADDR_PROGRAM_DATA;
    localparam logic [9:0] ENA = flash_err_pkg::ADDR_EVENT_ENABLE;
    localparam logic [9:0] SRC = flash_err_pkg::ADDR_EVENT_SOURCE;
    logic clk_sys_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, flash_write_i = 0;
    logic unit_busy_i, program_active_i, erase_active_i, irq_o;
    logic [5:0] ev = 6'h00;
    logic [9:0] reg_addr_i = 10'h000;
    logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o;
    logic [6:0] timer_expired_i, tsel = 7'h00;
    logic [15:0] flash_addr_i = 16'h0000, flash_wdata_i = 16'h0000;
    logic [11:0] event_pending_bits_o, en = 12'hFFF;
    int mismatches = 0, total_checks = 0, cyc = 0;
    wire logic iface_reg_write_i = ev[3], control_write_i = ev[2];
    wire logic flash_access_i = ev[1], pe_access_i = ev[0];
    flash_iface_error_status i_dut (.*);
    flash_seq_model i_seq (.clk_sys_i, .rst_i, .go_i(ev[5:4]), .tsel_i(tsel),
        .busy_o(unit_busy_i), .prog_o(program_active_i), .erase_o(erase_active_i),
        .timer_o(timer_expired_i));
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1;
        @(posedge clk_sys_i);
        reg_wr_i <= 0;
    endtask
    // Data stands only in the cycle after the read edge
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1;
        @(posedge clk_sys_i);
        reg_rd_i <= 0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    task automatic pulse(input logic [5:0] p);
        @(posedge clk_sys_i);
        ev <= p;
        @(posedge clk_sys_i);
        ev <= 6'h00;
    endtask
    task automatic evc(input logic [11:0] e);
        rd(SRC, {20'h0, e});
        rd(flash_err_pkg::ADDR_EVENT_PENDING, {20'h0, e & en});
        chk(irq_o, |(e & en));
        chk(event_pending_bits_o, e & en);
        wr(SRC, {20'h0, e});
        rd(SRC, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(CAP, 32'h00000000);
        rd(DAT, 32'h00000000);
        rd(SRC, 32'h00000000);
        rd(ENA, 32'h00000000);
        rd(10'h020, 32'h00000000);
        wr(ENA, 32'hFFFFFFFF);
        rd(ENA, 32'h00000FFF);
    endtask
    // Read at the top valid address must not count as out of range
    task automatic t_prog();
        flash_addr_i <= 16'h7FFF;
        pulse(6'h10);
        pulse(6'h08);
        pulse(6'h04);
        pulse(6'h02);
        flash_write_i <= 1;
        flash_addr_i <= 16'h0123;
        flash_wdata_i <= 16'hA5C3;
        pulse(6'h03);
        flash_write_i <= 0;
        evc(12'hC02);
        rd(DAT, 32'h0000A5C3);
        rd(CAP, 32'h00000123);
    endtask
    task automatic t_erase();
        for (int k = 0; k < 7; k++) begin
            tsel <= 7'h01 << k;
            pulse(6'h20);
            pulse(6'h02);
            for (int i = 0; i < 40 && unit_busy_i; i++) @(posedge clk_sys_i);
            evc(12'h004 | (12'h008 << k));
        end
    endtask
    task automatic t_range();
        for (int i = 0; i < 2; i++) begin
            en = i ? 12'h000 : 12'hFFF;
            wr(ENA, {20'h0, en});
            flash_addr_i <= 16'h8000;
            pulse(6'h02);
            evc(12'h001);
        end
    endtask
    // Frozen clock enable drops events; a mid-run reset clears every register
    task automatic t_freeze();
        @(posedge clk_sys_i);
        flash_addr_i <= 16'h8000;
        ce_i <= 0;
        pulse(6'h02);
        @(posedge clk_sys_i);
        ce_i <= 1;
        rd(SRC, 32'h00000000);
        pulse(6'h02);
        @(posedge clk_sys_i);
        rst_i <= 1;
        @(posedge clk_sys_i);
        rst_i <= 0;
        rd(SRC, 32'h00000000);
        rd(CAP, 32'h00000000);
        rd(DAT, 32'h00000000);
        rd(ENA, 32'h00000000);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 0;
        t_reset();
        t_prog();
        t_erase();
        t_range();
        t_freeze();
        end_of_test();
    end
endmodule // tb_flash_iface_error_status
`default_nettype wire
